// ==== include/cso_pkg.sv ====
package cso_pkg;

	// Avalon byte offsets of the two registers.
	localparam logic [3:0]  OFS_OPTIONS      = 4'h0;
	localparam logic [3:0]  OFS_STATUS       = 4'h4;

	// Field positions inside the 16-bit option register.
	localparam int          POS_MODE         = 15;
	localparam int          POS_BYTE_LO      = 13;
	localparam int          POS_DIR_LO       = 11;
	localparam int          POS_STROBE_SELECT         = 10;
	localparam int          POS_ACK_LO       = 6;
	localparam int          POS_SPACE_LO     = 4;
	localparam int          POS_IPL_LO       = 1;
	localparam int          POS_AUTOVECTOR_ENABLE         = 0;

	// Reset value leaves the channel disabled.
	localparam logic [15:0] OPTIONS_RESET    = 16'h0000;

	// Acknowledge field code that hands termination to the selected device.
	localparam logic [3:0]  ACK_EXTERNAL     = 4'hf;

	// Encodings of the byte-lane field.
	localparam logic [1:0]  BYTE_OFF         = 2'h0;
	localparam logic [1:0]  BYTE_LOWER       = 2'h1;
	localparam logic [1:0]  BYTE_UPPER       = 2'h2;

	// Encodings of the direction field.
	localparam logic [1:0]  DIR_READ         = 2'h1;
	localparam logic [1:0]  DIR_WRITE        = 2'h2;
	localparam logic [1:0]  DIR_BOTH         = 2'h3;

	// Encodings of the address-space field.
	localparam logic [1:0]  SPACE_CPU        = 2'h0;
	localparam logic [1:0]  SPACE_USER       = 2'h1;
	localparam logic [1:0]  SPACE_SUPER      = 2'h2;

	// Function code that marks a CPU space access, and the any-level code.
	localparam logic [2:0]  FC_CPU_SPACE     = 3'h7;
	localparam logic [2:0]  IPL_ANY          = 3'h0;

	// Transfer size code of a single byte.
	localparam logic [1:0]  SIZE_BYTE        = 2'h1;

	// Acknowledge patterns, active low: bit 1 for a 16-bit port, bit 0 for 8-bit.
	localparam logic [1:0]  ACK_NONE         = 2'h3;
	localparam logic [1:0]  ACK_PORT16       = 2'h1;
	localparam logic [1:0]  ACK_PORT8        = 2'h2;

	// Channel sequencer states.
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SYNC_WAIT,
		ST_ACTIVE
	} cso_state_t;

endpackage : cso_pkg

// ==== src/cso_chip_select_option_match.sv ====
`timescale 1ns/10ps
module cso_chip_select_option_match
(
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_SRST,
	input  wire logic        I_CLK_EN,
	input  wire logic [3:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	input  wire logic        I_ADDRESS_STROBE_N,
	input  wire logic        I_DATA_STROBE_N,
	input  wire logic        I_READ_CYCLE,
	input  wire logic [1:0]  I_TRANSFER_SIZE,
	input  wire logic        I_LOWEST_ADDRESS_BIT,
	input  wire logic [2:0]  I_FUNCTION_CODE,
	input  wire logic        I_BASE_ADDRESS_MATCH,
	input  wire logic        I_PORT_16BIT,
	input  wire logic        I_IACK_CYCLE,
	input  wire logic [2:0]  I_IACK_LEVEL,
	input  wire logic        I_IACK_FROM_PIN,
	input  wire logic        I_SLOW_PERIPHERAL_CLOCK,
	output logic             O_CHIP_SELECT_N,
	output logic [1:0]       O_DATA_SIZE_ACKNOWLEDGE_N,
	output logic             O_AUTOVECTOR_N
);

	// Byte-lane decision for one access.
	function automatic logic byte_ok(input logic [1:0] sel, input logic port16,
		input logic [1:0] size, input logic a0);
		logic lower;
		logic upper;
		lower = a0 | (size != cso_pkg::SIZE_BYTE);
		upper = ~a0;
		if (sel == cso_pkg::BYTE_OFF)
			byte_ok = 1'b0;
		else if (!port16)
			byte_ok = 1'b1;
		else if (sel == cso_pkg::BYTE_LOWER)
			byte_ok = lower;
		else if (sel == cso_pkg::BYTE_UPPER)
			byte_ok = upper;
		else
			byte_ok = 1'b1;
	endfunction : byte_ok

	// Direction decision; the reserved code never selects.
	function automatic logic dir_ok(input logic [1:0] sel, input logic rd);
		case (sel)
			cso_pkg::DIR_READ:  dir_ok = rd;
			cso_pkg::DIR_WRITE: dir_ok = ~rd;
			cso_pkg::DIR_BOTH:  dir_ok = 1'b1;
			default:            dir_ok = 1'b0;
		endcase
	endfunction : dir_ok

	// Address-space decision from the function code.
	function automatic logic space_ok(input logic [1:0] sel, input logic [2:0] fc);
		logic cpu;
		logic sup;
		logic usr;
		cpu = (fc == cso_pkg::FC_CPU_SPACE);
		sup = fc[2] & ~cpu;
		usr = ~fc[2];
		case (sel)
			cso_pkg::SPACE_CPU:   space_ok = cpu;
			cso_pkg::SPACE_USER:  space_ok = usr;
			cso_pkg::SPACE_SUPER: space_ok = sup;
			default:              space_ok = sup | usr;
		endcase
	endfunction : space_ok

	logic [15:0]         options_reg;
	logic                ack_reg;
	logic [31:0]         readdata_reg;
	cso_pkg::cso_state_t state_reg;
	cso_pkg::cso_state_t state_next;
	logic [3:0]          wait_reg;
	logic                slow_clk_prev_reg;
	logic                cs_n_reg;
	logic [1:0]          data_size_acknowledge_n_reg;
	logic                autovector_enable_n_reg;
	logic                match_reg;

	logic                opt_mode;
	logic [1:0]          opt_byte;
	logic [1:0]          opt_dir;
	logic                opt_strobe_select;
	logic [3:0]          opt_ack;
	logic [1:0]          opt_space;
	logic [2:0]          opt_ipl;
	logic                opt_autovector_enable;
	logic                level_ok;
	logic                cycle_match;
	logic                strobe_seen;
	logic                slow_clk_rise;
	logic                bus_req;
	logic                sel_options;
	logic                sel_status;
	logic                ack_internal;

	// Field extraction from the option register.
	assign opt_mode  = options_reg[cso_pkg::POS_MODE];
	assign opt_byte  = options_reg[cso_pkg::POS_BYTE_LO +: 2];
	assign opt_dir   = options_reg[cso_pkg::POS_DIR_LO +: 2];
	assign opt_strobe_select  = options_reg[cso_pkg::POS_STROBE_SELECT];
	assign opt_ack   = options_reg[cso_pkg::POS_ACK_LO +: 4];
	assign opt_space = options_reg[cso_pkg::POS_SPACE_LO +: 2];
	assign opt_ipl   = options_reg[cso_pkg::POS_IPL_LO +: 3];
	assign opt_autovector_enable  = options_reg[cso_pkg::POS_AUTOVECTOR_ENABLE];

	// Level check only narrows acknowledge cycles; other cycles pass it.
	assign level_ok = ~I_IACK_CYCLE | (opt_ipl == cso_pkg::IPL_ANY) |
		(opt_ipl == I_IACK_LEVEL);

	// All conditions must hold together while the address strobe is low.
	assign cycle_match = ~I_ADDRESS_STROBE_N & I_BASE_ADDRESS_MATCH
		& byte_ok(opt_byte, I_PORT_16BIT, I_TRANSFER_SIZE, I_LOWEST_ADDRESS_BIT)
		& dir_ok(opt_dir, I_READ_CYCLE)
		& space_ok(opt_space, I_FUNCTION_CODE)
		& level_ok;

	// Strobe select picks the qualifying strobe in asynchronous mode only.
	assign strobe_seen = opt_strobe_select ? ~I_DATA_STROBE_N : ~I_ADDRESS_STROBE_N;

	// Inputs are synchronous to the system clock, so one stage suffices for the edge.
	assign slow_clk_rise = I_SLOW_PERIPHERAL_CLOCK & ~slow_clk_prev_reg;

	// External acknowledge leaves termination to the selected device.
	assign ack_internal = ~opt_mode & (opt_ack != cso_pkg::ACK_EXTERNAL);

	// Bus decode; an unmapped offset reads zero and ignores writes.
	assign bus_req     = I_AVS_READ | I_AVS_WRITE;
	assign sel_options = (I_AVS_ADDRESS == cso_pkg::OFS_OPTIONS);
	assign sel_status  = (I_AVS_ADDRESS == cso_pkg::OFS_STATUS);

	// One wait cycle per access keeps read data registered.
	assign O_AVS_WAITREQUEST = bus_req & ~ack_reg;
	assign O_AVS_READDATA    = readdata_reg;

	// Strobe outputs come straight from their flip-flops.
	assign O_CHIP_SELECT_N           = cs_n_reg;
	assign O_DATA_SIZE_ACKNOWLEDGE_N = data_size_acknowledge_n_reg;
	assign O_AUTOVECTOR_N            = autovector_enable_n_reg;

	// Access acknowledge toggles high for exactly the completing cycle.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			ack_reg <= 1'b0;
		else if (I_CLK_EN)
			ack_reg <= bus_req & ~ack_reg;
	end

	// Option register write with byte lanes; takes effect at the completing edge.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			options_reg <= cso_pkg::OPTIONS_RESET;
		else if (I_CLK_EN && I_AVS_WRITE && ack_reg && sel_options)
		begin
			if (I_AVS_BYTEENABLE[0])
				options_reg[7:0] <= I_AVS_WRITEDATA[7:0];
			if (I_AVS_BYTEENABLE[1])
				options_reg[15:8] <= I_AVS_WRITEDATA[15:8];
		end
	end

	// Read data is captured in the wait cycle so it stands at the completing edge.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			readdata_reg <= 32'h0000_0000;
		else if (I_CLK_EN)
		begin
			if (I_AVS_READ && !ack_reg && sel_options)
				readdata_reg <= {16'h0000, options_reg};
			else if (I_AVS_READ && !ack_reg && sel_status)
				readdata_reg <= {24'h00_0000, wait_reg, match_reg, ~autovector_enable_n_reg,
					(data_size_acknowledge_n_reg != cso_pkg::ACK_NONE), ~cs_n_reg};
			else if (I_AVS_READ && !ack_reg)
				readdata_reg <= 32'h0000_0000;
		end
	end

	// Previous slow clock level for edge detection.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			slow_clk_prev_reg <= 1'b0;
		else if (I_CLK_EN)
			slow_clk_prev_reg <= I_SLOW_PERIPHERAL_CLOCK;
	end

	// Registered match indication, reloaded from cycle_match every enabled clock, visible in the status register.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			match_reg <= 1'b0;
		else if (I_CLK_EN)
			match_reg <= cycle_match;
	end

	// Sequencer next state; the cycle ends whenever the address strobe rises.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			cso_pkg::ST_IDLE:
			begin
				if (cycle_match && opt_mode)
					state_next = cso_pkg::ST_SYNC_WAIT;
				else if (cycle_match && strobe_seen)
					state_next = cso_pkg::ST_ACTIVE;
			end
			cso_pkg::ST_SYNC_WAIT:
			begin
				if (I_ADDRESS_STROBE_N)
					state_next = cso_pkg::ST_IDLE;
				else if (slow_clk_rise)
					state_next = cso_pkg::ST_ACTIVE;
			end
			cso_pkg::ST_ACTIVE:
			begin
				if (I_ADDRESS_STROBE_N)
					state_next = cso_pkg::ST_IDLE;
			end
			default:
				state_next = cso_pkg::ST_IDLE;
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			state_reg <= cso_pkg::ST_IDLE;
		else if (I_CLK_EN)
			state_reg <= state_next;
	end

	// Chip select follows the sequencer so it asserts one edge after the trigger.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			cs_n_reg <= 1'b1;
		else if (I_CLK_EN)
			cs_n_reg <= (state_next != cso_pkg::ST_ACTIVE);
	end

	// Wait-state counter loads on entry and counts down while selected.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			wait_reg <= 4'h0;
		else if (I_CLK_EN)
		begin
			if (state_reg != cso_pkg::ST_ACTIVE)
				wait_reg <= opt_ack;
			else if (wait_reg != 4'h0)
				wait_reg <= wait_reg - 4'h1;
		end
	end

	// Internal acknowledge after the wait states; port width picks the line.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			data_size_acknowledge_n_reg <= cso_pkg::ACK_NONE;
		else if (I_CLK_EN)
		begin
			if (state_reg == cso_pkg::ST_ACTIVE && state_next == cso_pkg::ST_ACTIVE &&
				ack_internal && wait_reg == 4'h0 && !opt_autovector_enable_hit(opt_autovector_enable))
				data_size_acknowledge_n_reg <= I_PORT_16BIT ? cso_pkg::ACK_PORT16 : cso_pkg::ACK_PORT8;
			else
				data_size_acknowledge_n_reg <= cso_pkg::ACK_NONE;
		end
	end

	// Autovector replaces the acknowledge on pin-caused interrupt acknowledges.
	function automatic logic opt_autovector_enable_hit(input logic en);
		opt_autovector_enable_hit = en & I_IACK_CYCLE & I_IACK_FROM_PIN;
	endfunction : opt_autovector_enable_hit

	// Autovector is held for the selected part of a matching acknowledge cycle.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			autovector_enable_n_reg <= 1'b1;
		else if (I_CLK_EN)
			autovector_enable_n_reg <= ~((state_next == cso_pkg::ST_ACTIVE) && opt_autovector_enable_hit(opt_autovector_enable));
	end

endmodule : cso_chip_select_option_match

// ==== tb/cso_chip_select_option_match_monitor.sv ====
`timescale 1ns/10ps
module cso_monitor
(
	input wire logic        I_CLK_SYS,
	input wire logic        I_SRST,
	input wire logic [3:0]  I_AVS_ADDRESS,
	input wire logic        I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0]  I_AVS_BYTEENABLE,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic        I_ADDRESS_STROBE_N,
	input wire logic        I_DATA_STROBE_N,
	input wire logic        I_READ_CYCLE,
	input wire logic [1:0]  I_TRANSFER_SIZE,
	input wire logic        I_LOWEST_ADDRESS_BIT,
	input wire logic [2:0]  I_FUNCTION_CODE,
	input wire logic        I_PORT_16BIT,
	input wire logic        I_IACK_CYCLE,
	input wire logic [2:0]  I_IACK_LEVEL,
	input wire logic        I_IACK_FROM_PIN,
	input wire logic        O_CHIP_SELECT_N,
	input wire logic [1:0]  O_DATA_SIZE_ACKNOWLEDGE_N,
	input wire logic        O_AUTOVECTOR_N
);
	logic [15:0] opt_reg;
	logic [4:0]  age_reg;
	logic        lane_ok;
	logic        dir_ok;
	logic        space_ok;
	// The option register is mirrored from the bus, since only the ports are visible.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			opt_reg <= cso_pkg::OPTIONS_RESET;
		else if (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == cso_pkg::OFS_OPTIONS)
			opt_reg <= I_AVS_WRITEDATA[15:0];
	end
	// Cycles spent with chip select low, for the wait-state count.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST || O_CHIP_SELECT_N)
			age_reg <= 5'h0;
		else
			age_reg <= age_reg + 5'h1;
	end
	// Lane, direction and space decode worked out independently of the design.
	assign lane_ok = I_PORT_16BIT ? ((opt_reg[13] && (I_LOWEST_ADDRESS_BIT
		|| I_TRANSFER_SIZE != cso_pkg::SIZE_BYTE)) || (opt_reg[14] && !I_LOWEST_ADDRESS_BIT))
		: opt_reg[14:13] != 2'h0;
	assign dir_ok = I_READ_CYCLE ? opt_reg[11] : opt_reg[12];
	assign space_ok = (I_FUNCTION_CODE == cso_pkg::FC_CPU_SPACE) ? opt_reg[5:4] == 2'h0
		: (I_FUNCTION_CODE[2] ? opt_reg[5] : opt_reg[4]);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SRST);
	sequence s_cs_start;
		$fell(O_CHIP_SELECT_N);
	endsequence
	sequence s_ack_start;
		O_DATA_SIZE_ACKNOWLEDGE_N != 2'h3 && $past(O_DATA_SIZE_ACKNOWLEDGE_N) == 2'h3;
	endsequence
	a_lane_match: assert property (s_cs_start |-> $past(lane_ok))
		else $error("chip select outside enabled byte lane");
	a_dir_match: assert property (s_cs_start |-> $past(dir_ok))
		else $error("chip select on wrong direction");
	a_space_match: assert property (s_cs_start |-> $past(space_ok))
		else $error("chip select in wrong address space");
	a_level_match: assert property (s_cs_start and $past(I_IACK_CYCLE) |->
		$past(opt_reg[3:1] == cso_pkg::IPL_ANY || opt_reg[3:1] == I_IACK_LEVEL))
		else $error("chip select on wrong interrupt level");
	a_strobe_timing: assert property (s_cs_start and !$past(opt_reg[15]) |->
		$past(opt_reg[10] ? !I_DATA_STROBE_N : !I_ADDRESS_STROBE_N))
		else $error("chip select before selected strobe");
	a_ack_source: assert property (s_ack_start |-> !$past(opt_reg[15])
		&& $past(opt_reg[9:6]) != cso_pkg::ACK_EXTERNAL)
		else $error("internal acknowledge in sync or external mode");
	a_wait_count: assert property (s_ack_start |->
		age_reg == {1'b0, $past(opt_reg[9:6])} + 5'h1)
		else $error("acknowledge wait count wrong");
	a_autovector_enable_cause: assert property ($fell(O_AUTOVECTOR_N) |->
		$past(opt_reg[0] && I_IACK_CYCLE && I_IACK_FROM_PIN))
		else $error("autovector without enabled pin acknowledge");
	a_cycle_release: assert property ($rose(I_ADDRESS_STROBE_N) |=> O_CHIP_SELECT_N
		&& O_AUTOVECTOR_N && O_DATA_SIZE_ACKNOWLEDGE_N == 2'h3)
		else $error("outputs not released after strobe");
endmodule : cso_monitor
bind cso_chip_select_option_match cso_monitor mon_u (.*);

// ==== tb/cso_peripheral_model.sv ====
`timescale 1ns/10ps
module cso_peripheral_model
(
	input  wire logic       i_clk,
	input  wire logic       i_cs_n,
	input  wire logic [1:0] i_delay,
	output logic      [1:0] o_ack_n
);
	logic [1:0] cnt_reg;
	// The selected device ends the cycle itself; lines are pulled up when released.
	always_ff @(posedge i_clk)
	begin
		if (i_cs_n)
		begin
			cnt_reg <= i_delay;
			o_ack_n <= 2'h3;
		end
		else if (cnt_reg != 2'h0)
			cnt_reg <= cnt_reg - 2'h1;
		else
			o_ack_n <= 2'h1;
	end
endmodule : cso_peripheral_model

// ==== tb/cso_chip_select_option_match_tb.sv ====
`timescale 1ns/10ps
module cso_chip_select_option_match_tb;
	logic I_CLK_SYS = 0, I_SRST = 1, I_CLK_EN = 1, I_AVS_READ = 0, I_AVS_WRITE = 0;
	logic [3:0] I_AVS_ADDRESS = 0, I_AVS_BYTEENABLE = 4'hf;
	logic [31:0] I_AVS_WRITEDATA = 0, O_AVS_READDATA;
	logic I_ADDRESS_STROBE_N = 1, I_DATA_STROBE_N = 1, I_READ_CYCLE = 0, I_PORT_16BIT = 0;
	logic I_LOWEST_ADDRESS_BIT = 0, I_BASE_ADDRESS_MATCH = 0, I_IACK_CYCLE = 0;
	logic I_IACK_FROM_PIN = 0, I_SLOW_PERIPHERAL_CLOCK = 0, O_AVS_WAITREQUEST;
	logic [1:0] I_TRANSFER_SIZE = 0, O_DATA_SIZE_ACKNOWLEDGE_N, ext_ack_n;
	logic [2:0] I_FUNCTION_CODE = 0, I_IACK_LEVEL = 0, sdiv = 0;
	logic O_CHIP_SELECT_N, O_AUTOVECTOR_N;
	int n_mismatch = 0, n_compared = 0;
	cso_chip_select_option_match dut_u (.*);
	cso_peripheral_model per_u (.i_clk(I_CLK_SYS), .i_cs_n(O_CHIP_SELECT_N),
		.i_delay(2'h2), .o_ack_n(ext_ack_n));
	always #25 I_CLK_SYS = ~I_CLK_SYS;
	// The slow peripheral clock runs free at one eighth of the system rate.
	always @(posedge I_CLK_SYS)
	begin
		sdiv <= sdiv + 3'h1;
		I_SLOW_PERIPHERAL_CLOCK <= sdiv[2];
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Avalon access; the request holds until the rising edge that sees waitrequest low.
	// Read data is taken at that same edge, and one idle edge separates two accesses.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		I_AVS_ADDRESS <= a;
		I_AVS_WRITEDATA <= d;
		I_AVS_WRITE <= wr;
		I_AVS_READ <= !wr;
		do @(posedge I_CLK_SYS); while (O_AVS_WAITREQUEST !== 1'b0);
		q = O_AVS_READDATA;
		I_AVS_WRITE <= 1'b0;
		I_AVS_READ <= 1'b0;
		@(posedge I_CLK_SYS);
	endtask : bus
	// One bus cycle; f is {read, a0, port16, iack, base hit, data strobe}, ex is {cs, autovector_enable}.
	task automatic cyc(input logic [15:0] opt, input logic [2:0] fc, input logic [5:0] f,
		input logic [1:0] sz, input logic [2:0] lvl, input logic [1:0] ex);
		logic [31:0] q;
		int cs_at = -1, ack_at = -1, p_at = -1;
		logic av = 0;
		bus(1'b1, cso_pkg::OFS_OPTIONS, {16'h0000, opt}, q);
		I_FUNCTION_CODE <= fc;
		{I_READ_CYCLE, I_LOWEST_ADDRESS_BIT, I_PORT_16BIT, I_IACK_CYCLE} <= f[5:2];
		I_IACK_FROM_PIN <= f[2];
		I_BASE_ADDRESS_MATCH <= f[1];
		I_TRANSFER_SIZE <= sz;
		I_IACK_LEVEL <= lvl;
		I_ADDRESS_STROBE_N <= 1'b0;
		I_DATA_STROBE_N <= !f[0];
		for (int i = 0; i < 24; i++)
		begin
			@(negedge I_CLK_SYS);
			if (cs_at < 0 && O_CHIP_SELECT_N === 1'b0)
				cs_at = i;
			if (ack_at < 0 && O_DATA_SIZE_ACKNOWLEDGE_N !== 2'h3)
				ack_at = i;
			if (p_at < 0 && ext_ack_n === 2'h1)
				p_at = i;
			if (O_AUTOVECTOR_N === 1'b0)
				av = 1;
		end
		chk("chip select", ex[1], cs_at >= 0);
		chk("autovector", ex[0], av);
		if (ex[1] && !opt[15] && opt[9:6] != cso_pkg::ACK_EXTERNAL && !ex[0])
			chk("ack delay", opt[9:6] + 1, ack_at - cs_at);
		else
			chk("ack idle", 0, ack_at >= 0);
		if (ex[1] && opt[9:6] == cso_pkg::ACK_EXTERNAL)
			chk("peripheral ack", 1, p_at >= 0);
		@(posedge I_CLK_SYS);
		I_ADDRESS_STROBE_N <= 1'b1;
		I_DATA_STROBE_N <= 1'b1;
		@(posedge I_CLK_SYS);
		@(negedge I_CLK_SYS);
		chk("release", 4'hf, {O_CHIP_SELECT_N, O_AUTOVECTOR_N, O_DATA_SIZE_ACKNOWLEDGE_N});
		@(posedge I_CLK_SYS);
	endtask : cyc
	task automatic t_regs();
		logic [31:0] q;
		bus(1'b0, cso_pkg::OFS_STATUS, 32'h0, q);
		chk("status reset", 32'h0000_0000, q);
		bus(1'b0, cso_pkg::OFS_OPTIONS, 32'h0, q);
		chk("options reset", {16'h0000, cso_pkg::OPTIONS_RESET}, q);
		bus(1'b1, cso_pkg::OFS_OPTIONS, 32'hffff_1234, q);
		bus(1'b0, cso_pkg::OFS_OPTIONS, 32'h0, q);
		chk("options", 32'h0000_1234, q);
		bus(1'b1, 4'h8, 32'hffff_ffff, q);
		bus(1'b0, 4'h8, 32'h0, q);
		chk("unmapped", 32'h0000_0000, q);
	endtask : t_regs
	task automatic t_lanes();
		cyc(16'h7830, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b10);
		cyc(16'h1830, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b00);
		cyc(16'h3830, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b00);
		cyc(16'h3830, 3'h5, 6'b011011, 2'h1, 3'h0, 2'b10);
		cyc(16'h3830, 3'h5, 6'b001011, 2'h2, 3'h0, 2'b10);
		cyc(16'h5830, 3'h5, 6'b011011, 2'h1, 3'h0, 2'b00);
		cyc(16'h5830, 3'h5, 6'b010011, 2'h1, 3'h0, 2'b10);
	endtask : t_lanes
	task automatic t_dir_space();
		cyc(16'h6830, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b00);
		cyc(16'h6830, 3'h5, 6'b101011, 2'h1, 3'h0, 2'b10);
		cyc(16'h7030, 3'h5, 6'b101011, 2'h1, 3'h0, 2'b00);
		cyc(16'h7810, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b00);
		cyc(16'h7810, 3'h1, 6'b001011, 2'h1, 3'h0, 2'b10);
		cyc(16'h7820, 3'h1, 6'b001011, 2'h1, 3'h0, 2'b00);
		cyc(16'h7800, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b00);
		cyc(16'h7830, 3'h5, 6'b001001, 2'h1, 3'h0, 2'b00);
	endtask : t_dir_space
	task automatic t_level();
		cyc(16'h7807, 3'h7, 6'b101111, 2'h1, 3'h3, 2'b11);
		cyc(16'h7807, 3'h7, 6'b101111, 2'h1, 3'h4, 2'b00);
		cyc(16'h7801, 3'h7, 6'b101111, 2'h1, 3'h7, 2'b11);
		cyc(16'h7806, 3'h7, 6'b101111, 2'h1, 3'h3, 2'b10);
	endtask : t_level
	task automatic t_timing();
		cyc(16'h7c30, 3'h5, 6'b001010, 2'h1, 3'h0, 2'b00);
		cyc(16'h7c30, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b10);
		cyc(16'h7830, 3'h5, 6'b001010, 2'h1, 3'h0, 2'b10);
		cyc(16'hfc30, 3'h5, 6'b001010, 2'h1, 3'h0, 2'b10);
		cyc(16'h78f0, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b10);
		cyc(16'h7bb0, 3'h5, 6'b000011, 2'h1, 3'h0, 2'b10);
		cyc(16'h7bf0, 3'h5, 6'b001011, 2'h1, 3'h0, 2'b10);
	endtask : t_timing
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// Reset for three cycles, then the scenarios in turn.
	initial
	begin
		repeat (3) @(posedge I_CLK_SYS);
		I_SRST <= 1'b0;
		t_regs();
		t_lanes();
		t_dir_space();
		t_level();
		t_timing();
		stop_test();
	end
	// About 29 cycles per bus cycle; the limit leaves ample margin.
	initial
	begin
		repeat (5000) @(posedge I_CLK_SYS);
		n_mismatch++;
		stop_test();
	end
endmodule : cso_chip_select_option_match_tb
